// File: core/atsp_cache_port.sv
// cache end of the translation stream port with AHB-Lite control registers
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
// Contract
// - completer channels share one agreed alignment
// - requester channels share one agreed alignment
// - completer straddle up to four, dword aligned
// - completion straddle two at 256 bits
// - requester straddle four/two, wide eight/four
// - translations keyed per PASID, invalidation global
// - stream parity off, generate, or generate-check
// - unchecked parity errors still processed normally
// - timeout 0..8191 ms, zero disables
// - integrity enables parity on cache storage
module atsp_cache_port
  import atsp_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYCLES_PER_MS
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // stream link
  atsp_if.cache_end lnk,
  // page request handshake with the user side
  output logic pri_fail
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [DATA_W-1:0] ctrl;
  logic [TMO_W-1:0] tmo_ms;
  logic [PASID_W-1:0] pri_pasid;
  logic pri_go;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [DATA_W-1:0] next_rdata;
  logic par_err_flag;
  logic other_err_flag;
  logic [7:0] hits;
  logic [7:0] drops;
  atsp_pri_e pri_state;
  logic [DATA_W-1:0] ms_div;
  logic [TMO_W-1:0] ms_cnt;
  logic ms_tick;
  logic par_gen;
  logic par_chk;
  logic cache_par_err;
  logic rc_par_bad;
  logic rc_take;
  assign hresp = 1'b0;
  assign par_gen = ctrl[CTRL_PAR_LO +: 2] != PAR_DISABLE;
  assign par_chk = ctrl[CTRL_PAR_LO +: 2] == PAR_GEN_CHECK;
  // address phase capture; write data lands one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hreadyout <= 1'b1;
      hrdata <= '0;
    end else begin
      wr_pend <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
      wr_addr <= haddr[7:0];
      if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end
  // read decode; unmapped reads zero
  always_comb begin
    next_rdata = '0;
    case (haddr[7:0])
      REG_CTRL: next_rdata = ctrl;
      REG_TMO: next_rdata = DATA_W'(tmo_ms);
      REG_STATUS: next_rdata = {16'h0000, hits, 3'h0, par_err_flag, other_err_flag,
                                cache_par_err, pri_state};
      REG_PRI: next_rdata = {drops, 4'h0, pri_pasid};
      REG_LIMITS: next_rdata = {20'h00000, lnk.straddle_rq, lnk.straddle_rc, lnk.straddle_c};
      default: next_rdata = '0;
    endcase
  end
  // timeout register truncated to its low 13 bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= DATA_W'(CTRL_WIDTH_RST) << 16;
      tmo_ms <= '0;
      pri_pasid <= '0;
      pri_go <= 1'b0;
    end else begin
      pri_go <= 1'b0;
      if (wr_pend && wr_addr == REG_CTRL) begin
        ctrl <= hwdata;
      end
      if (wr_pend && wr_addr == REG_TMO) begin
        tmo_ms <= hwdata[TMO_W-1:0];
      end
      if (wr_pend && wr_addr == REG_PRI) begin
        pri_pasid <= hwdata[PASID_W-1:0];
        pri_go <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // configuration that the endpoint must match
  // ----------------------------------------
  // completer and requester alignment; completer straddle
  assign lnk.align_c = ctrl[CTRL_ALIGN_C];
  assign lnk.align_r = ctrl[CTRL_ALIGN_R];
  assign lnk.straddle_c = atsp_limit(ctrl[CTRL_STR_C], ctrl[CTRL_ALIGN_C], ctrl[26:16],
                                     ctrl[CTRL_WIDE], STRADDLE_NONE, STRADDLE_FOUR,
                                     STRADDLE_FOUR);
  // completion straddle: two at 256, four or eight wider
  assign lnk.straddle_rc = atsp_limit(ctrl[CTRL_STR_R], ctrl[CTRL_ALIGN_R], ctrl[26:16],
                                      ctrl[CTRL_WIDE], STRADDLE_TWO, STRADDLE_FOUR,
                                      STRADDLE_EIGHT);
  // request straddle: none at 256, two or four on wide variant wider
  assign lnk.straddle_rq = atsp_limit(ctrl[CTRL_STR_R], ctrl[CTRL_ALIGN_R], ctrl[26:16],
                                      ctrl[CTRL_WIDE], STRADDLE_NONE, STRADDLE_TWO,
                                      STRADDLE_FOUR);
  // ----------------------------------------
  // completer request path through FIFO
  // ----------------------------------------
  logic [DATA_W-1:0] cq_q;
  logic cq_q_valid;
  logic cq_q_ready;
  atsp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_data(lnk.cq_data),
    .in_valid(lnk.cq_valid),
    .in_ready(lnk.cq_ready),
    .out_data(cq_q),
    .out_valid(cq_q_valid),
    .out_ready(cq_q_ready)
  );
  // translation store: pasid tag, page, parity; drains stall on cc back-pressure
  logic [PASID_W-1:0] tag [CACHE_ENTRIES];
  logic [DATA_W-1:0] page [CACHE_ENTRIES];
  logic tpar [CACHE_ENTRIES];
  logic [CACHE_ENTRIES-1:0] vld;
  logic [CACHE_ENTRIES-1:0] hit_vec;
  logic [1:0] fill_ptr;
  logic [DATA_W-1:0] hit_page;
  assign cq_q_ready = !lnk.cc_valid || lnk.cc_ready;
  for (genvar gi = 0; gi < CACHE_ENTRIES; gi++) begin : g_hit
    assign hit_vec[gi] = vld[gi] && tag[gi] == cq_q[PASID_W-1:0];
  end
  // hit select, storage parity under integrity
  always_comb begin
    hit_page = '0;
    cache_par_err = 1'b0;
    for (int i = 0; i < CACHE_ENTRIES; i++) begin
      if (hit_vec[i]) begin
        hit_page = page[i];
        cache_par_err = cache_par_err || (ctrl[CTRL_INTEG] && (^page[i] != tpar[i]));
      end
    end
  end
  // completion answer; parity generated only when enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.cc_valid <= 1'b0;
      lnk.cc_data <= '0;
      lnk.cc_par <= 1'b0;
      hits <= '0;
    end else if (cq_q_ready) begin
      lnk.cc_valid <= cq_q_valid;
      lnk.cc_data <= (|hit_vec) ? hit_page : '0;
      lnk.cc_par <= par_gen ? ^((|hit_vec) ? hit_page : '0) : 1'b0;
      hits <= hits + 8'(cq_q_valid && (|hit_vec));
    end
  end
  // ----------------------------------------
  // page request with timeout
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.rq_valid <= 1'b0;
      lnk.rq_data <= '0;
      lnk.rq_par <= 1'b0;
    end else if (pri_go) begin
      lnk.rq_valid <= 1'b1;
      lnk.rq_data <= DATA_W'(pri_pasid);
      lnk.rq_par <= par_gen ? ^pri_pasid : 1'b0;
    end else if (lnk.rq_ready) begin
      lnk.rq_valid <= 1'b0;
    end
  end
  assign lnk.rc_ready = 1'b1;
  // millisecond enable pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_div <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= ms_div == DATA_W'(CYC_PER_MS - 1);
      ms_div <= (ms_div == DATA_W'(CYC_PER_MS - 1) || pri_go) ? '0 : ms_div + 32'h1;
    end
  end
  // timer starts at issue; zero never expires
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pri_state <= ATSP_PRI_IDLE;
      ms_cnt <= '0;
      pri_fail <= 1'b0;
    end else begin
      case (pri_state)
        ATSP_PRI_IDLE, ATSP_PRI_DONE, ATSP_PRI_FAIL: begin
          if (pri_go) begin
            pri_state <= ATSP_PRI_WAIT;
            ms_cnt <= '0;
            pri_fail <= 1'b0;
          end
        end
        ATSP_PRI_WAIT: begin
          // a dropped completion is no answer, so the wait goes on
          if (rc_take) begin
            pri_state <= ATSP_PRI_DONE;
          end else if (tmo_ms != '0 && ms_tick) begin
            if (ms_cnt + 13'h1 >= tmo_ms) begin
              pri_state <= ATSP_PRI_FAIL;
              pri_fail <= 1'b1;
            end
            ms_cnt <= ms_cnt + 13'h1;
          end
        end
        default: pri_state <= ATSP_PRI_IDLE;
      endcase
    end
  end
  // parity errors drop packets only when checking
  assign rc_par_bad = lnk.rc_valid && (^lnk.rc_data != lnk.rc_par);
  assign rc_take = lnk.rc_valid && !lnk.rc_err && !(par_chk && rc_par_bad);
  // fill per pasid, global invalidate wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vld <= '0;
      fill_ptr <= '0;
      drops <= '0;
      par_err_flag <= 1'b0;
      other_err_flag <= 1'b0;
    end else begin
      par_err_flag <= par_err_flag || (rc_par_bad && par_chk);
      other_err_flag <= other_err_flag || (lnk.rc_valid && lnk.rc_err);
      drops <= drops + 8'(lnk.rc_valid && !rc_take);
      if (ctrl[CTRL_INV]) begin
        vld <= '0;
      end else if (rc_take && ctrl[CTRL_PASID] && pri_state == ATSP_PRI_WAIT) begin
        vld[fill_ptr] <= 1'b1;
        fill_ptr <= fill_ptr + 2'h1;
      end
    end
  end
  always_ff @(posedge hclk) begin
    if (rc_take && pri_state == ATSP_PRI_WAIT) begin
      tag[fill_ptr] <= pri_pasid;
      page[fill_ptr] <= lnk.rc_data;
      tpar[fill_ptr] <= ^lnk.rc_data;
    end
  end
endmodule

// File: core/atsp_endpoint.sv
// endpoint end: drives completer requests and requester completions from a user port
`timescale 1ns/100ps
module atsp_endpoint
  import atsp_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // stream link
  atsp_if.endpoint_end lnk,
  // user: completer request to send
  input wire logic [DATA_W-1:0] u_cq_data,
  input wire logic u_cq_valid,
  output logic u_cq_busy,
  // user: requester completion to send
  input wire logic [DATA_W-1:0] u_rc_data,
  input wire logic u_rc_valid,
  input wire logic u_rc_bad_par,
  input wire logic u_rc_err,
  // user: observed words from the cache
  output logic [DATA_W-1:0] u_rq_data,
  output logic u_rq_strobe,
  output logic [DATA_W-1:0] u_cc_data,
  output logic u_cc_strobe,
  output logic u_par_err
);
  // ----------------------------------------
  // outgoing beats held until taken
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.cq_valid <= 1'b0;
      lnk.cq_data <= '0;
      lnk.cq_par <= 1'b0;
      lnk.cq_last <= 1'b0;
    end else if (!lnk.cq_valid || lnk.cq_ready) begin
      lnk.cq_valid <= u_cq_valid;
      lnk.cq_data <= u_cq_data;
      lnk.cq_par <= ^u_cq_data;
      lnk.cq_last <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.rc_valid <= 1'b0;
      lnk.rc_data <= '0;
      lnk.rc_par <= 1'b0;
      lnk.rc_err <= 1'b0;
    end else if (!lnk.rc_valid || lnk.rc_ready) begin
      lnk.rc_valid <= u_rc_valid;
      lnk.rc_data <= u_rc_data;
      lnk.rc_par <= (^u_rc_data) ^ u_rc_bad_par;
      lnk.rc_err <= u_rc_err;
    end
  end

  // busy mirrors the held completer beat
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      u_cq_busy <= 1'b0;
    end else begin
      u_cq_busy <= lnk.cq_valid && !lnk.cq_ready;
    end
  end

  // ----------------------------------------
  // incoming beats, always accepted
  // ----------------------------------------
  assign lnk.cc_ready = 1'b1;
  assign lnk.rq_ready = 1'b1;

  // capture and parity check of cache output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      u_rq_data <= '0;
      u_rq_strobe <= 1'b0;
      u_cc_data <= '0;
      u_cc_strobe <= 1'b0;
      u_par_err <= 1'b0;
    end else begin
      u_rq_strobe <= lnk.rq_valid;
      u_cc_strobe <= lnk.cc_valid;
      if (lnk.rq_valid) begin
        u_rq_data <= lnk.rq_data;
      end
      if (lnk.cc_valid) begin
        u_cc_data <= lnk.cc_data;
      end
      u_par_err <= (lnk.rq_valid && (^lnk.rq_data != lnk.rq_par)) ||
                   (lnk.cc_valid && (^lnk.cc_data != lnk.cc_par));
    end
  end
endmodule

// File: core/atsp_fifo.sv
// parameterised valid/ready FIFO
`timescale 1ns/100ps
module atsp_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage, no reset needed on data
  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: core/atsp_if.sv
// interface joining the endpoint end and the cache end of the stream port
`timescale 1ns/100ps
interface atsp_if;
  import atsp_pkg::*;
  // completer request / completion channels
  logic [DATA_W-1:0] cq_data;
  logic cq_valid;
  logic cq_ready;
  logic cq_last;
  logic cq_par;
  logic [DATA_W-1:0] cc_data;
  logic cc_valid;
  logic cc_ready;
  logic cc_par;
  // requester request / completion channels
  logic [DATA_W-1:0] rq_data;
  logic rq_valid;
  logic rq_ready;
  logic rq_par;
  logic [DATA_W-1:0] rc_data;
  logic rc_valid;
  logic rc_ready;
  logic rc_par;
  logic rc_err;
  // configuration both sides must agree on
  logic align_c;
  logic align_r;
  logic [3:0] straddle_c;
  logic [3:0] straddle_rc;
  logic [3:0] straddle_rq;

  modport cache_end (
    input cq_data, cq_valid, cq_last, cq_par, cc_ready, rq_ready, rc_data, rc_valid,
    rc_par, rc_err,
    output cq_ready, cc_data, cc_valid, cc_par, rq_data, rq_valid, rq_par, rc_ready,
    align_c, align_r, straddle_c, straddle_rc, straddle_rq
  );
  modport endpoint_end (
    output cq_data, cq_valid, cq_last, cq_par, cc_ready, rq_ready, rc_data, rc_valid,
    rc_par, rc_err,
    input cq_ready, cc_data, cc_valid, cc_par, rq_data, rq_valid, rq_par, rc_ready,
    align_c, align_r, straddle_c, straddle_rc, straddle_rq
  );
endinterface

// File: core/atsp_pkg.sv
// package of constants and types shared by both ends of the translation stream port
package atsp_pkg;

  // ----------------------------------------
  // stream geometry
  // ----------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned KEEP_W = 4;
  localparam int unsigned PASID_W = 20;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned CACHE_ENTRIES = 4;

  // ----------------------------------------
  // configuration encodings
  // ----------------------------------------
  localparam logic ALIGN_DWORD = 1'b0;
  localparam logic ALIGN_ADDR = 1'b1;
  localparam logic [1:0] PAR_DISABLE = 2'h0;
  localparam logic [1:0] PAR_GEN = 2'h1;
  localparam logic [1:0] PAR_GEN_CHECK = 2'h2;

  // straddle limits in packets per beat
  localparam logic [3:0] STRADDLE_NONE = 4'h1;
  localparam logic [3:0] STRADDLE_TWO = 4'h2;
  localparam logic [3:0] STRADDLE_FOUR = 4'h4;
  localparam logic [3:0] STRADDLE_EIGHT = 4'h8;
  localparam logic [10:0] WIDTH_256 = 11'h100;
  localparam logic [10:0] WIDTH_512 = 11'h200;
  localparam logic [10:0] WIDTH_1024 = 11'h400;

  // ----------------------------------------
  // page request timeout
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned TMO_W = 13;
  localparam logic [TMO_W-1:0] TMO_MAX = 13'h1FFF;

  // ----------------------------------------
  // AHB-Lite control registers
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TMO = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PRI = 8'h0C;
  localparam logic [7:0] REG_LIMITS = 8'h10;
  localparam int unsigned CTRL_ALIGN_C = 0;
  localparam int unsigned CTRL_ALIGN_R = 1;
  localparam int unsigned CTRL_PASID = 2;
  localparam int unsigned CTRL_INTEG = 3;
  localparam int unsigned CTRL_PAR_LO = 4;
  localparam int unsigned CTRL_STR_C = 6;
  localparam int unsigned CTRL_STR_R = 7;
  localparam int unsigned CTRL_INV = 8;
  localparam int unsigned CTRL_WIDE = 9;
  localparam logic [10:0] CTRL_WIDTH_RST = 11'h100;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    ATSP_PRI_IDLE = 2'b00,
    ATSP_PRI_WAIT = 2'b01,
    ATSP_PRI_DONE = 2'b10,
    ATSP_PRI_FAIL = 2'b11
  } atsp_pri_e;

  // straddle limit for one channel given configuration
  function automatic logic [3:0] atsp_limit(input logic en, input logic align,
                                            input logic [10:0] width, input logic wide,
                                            input logic [3:0] l256, input logic [3:0] l512,
                                            input logic [3:0] lwide);
    logic [3:0] r;
    r = STRADDLE_NONE;
    if (en && align == ALIGN_DWORD) begin
      if (width == WIDTH_256) begin
        r = l256;
      end else if (width == WIDTH_512 || width == WIDTH_1024) begin
        r = wide ? lwide : l512;
      end
    end
    return r;
  endfunction

endpackage

// File: dv/address_translation_stream_port_tb.sv
// self-checking bench driving both ends of the translation stream port
`timescale 1ns/100ps
module address_translation_stream_port_tb;
  import atsp_pkg::*;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  localparam int unsigned CPM = 4;
  localparam logic [1:0] PM[5] = '{PAR_DISABLE, PAR_GEN_CHECK, PAR_GEN, PAR_GEN_CHECK,
    PAR_GEN_CHECK};
  localparam logic [4:0] BAD_T = 5'b10011;
  localparam logic [4:0] ERR_T = 5'b00100;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pri_fail;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [DATA_W-1:0] hwdata, hrdata, u_cq_data, u_rc_data, u_rq_data, u_cc_data, rd;
  logic u_cq_valid, u_cq_busy, u_rc_valid, u_rc_bad_par, u_rc_err;
  logic u_rq_strobe, u_cc_strobe, u_par_err;
  logic [DATA_W-1:0] rqq[$], ccq[$];
  logic [DATA_W-1:0] page[int];
  int n_mismatch, tests_run, seed, err_seen, n_pe, x_pe;
  atsp_if lnk();
  atsp_cache_port #(.CYC_PER_MS(CPM)) atsp_cache_port_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lnk(lnk), .pri_fail(pri_fail)
  );
  atsp_endpoint atsp_endpoint_inst (
    .hclk(hclk), .hresetn(hresetn), .lnk(lnk), .u_cq_data(u_cq_data),
    .u_cq_valid(u_cq_valid), .u_cq_busy(u_cq_busy), .u_rc_data(u_rc_data),
    .u_rc_valid(u_rc_valid), .u_rc_bad_par(u_rc_bad_par), .u_rc_err(u_rc_err),
    .u_rq_data(u_rq_data), .u_rq_strobe(u_rq_strobe), .u_cc_data(u_cc_data),
    .u_cc_strobe(u_cc_strobe), .u_par_err(u_par_err)
  );
  atsp_link_asserts atsp_link_asserts_inst (
    .hclk(hclk), .hresetn(hresetn), .cq_data(lnk.cq_data), .cq_valid(lnk.cq_valid),
    .cq_ready(lnk.cq_ready), .cq_par(lnk.cq_par), .cc_data(lnk.cc_data),
    .cc_valid(lnk.cc_valid), .cc_par(lnk.cc_par), .rq_data(lnk.rq_data),
    .rq_valid(lnk.rq_valid), .align_c(lnk.align_c), .align_r(lnk.align_r),
    .straddle_c(lnk.straddle_c), .straddle_rc(lnk.straddle_rc), .straddle_rq(lnk.straddle_rq)
  );
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // single word transfer, address phase held until hready is seen
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [DATA_W-1:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic send_cq(input logic [DATA_W-1:0] d);
    @(posedge hclk);
    while (u_cq_busy === 1'b1) @(posedge hclk);
    u_cq_data <= d;
    u_cq_valid <= 1'b1;
    @(posedge hclk);
    u_cq_valid <= 1'b0;
  endtask
  task automatic send_rc(input logic [DATA_W-1:0] d, input logic bad, input logic err);
    @(posedge hclk);
    u_rc_data <= d;
    u_rc_bad_par <= bad;
    u_rc_err <= err;
    u_rc_valid <= 1'b1;
    @(posedge hclk);
    u_rc_valid <= 1'b0;
  endtask
  // strobes last one cycle, so a monitor queues them for later comparison
  task automatic expect_word(input logic cc, input logic [DATA_W-1:0] exp);
    for (int k = 0; k < 40 && (cc ? ccq.size() : rqq.size()) == 0; k++) @(posedge hclk);
    rd = 'x;
    if (cc && ccq.size() > 0) rd = ccq.pop_front();
    if (!cc && rqq.size() > 0) rd = rqq.pop_front();
    check(rd, exp);
  endtask
  always @(posedge hclk) begin
    if (u_rq_strobe === 1'b1) rqq.push_back(u_rq_data);
    if (u_cc_strobe === 1'b1) ccq.push_back(u_cc_data);
    if (u_par_err === 1'b1) n_pe++;
  end
  // free-running bus clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // watchdog well past the fewer than a thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    logic [10:0] w;
    logic [4:0] b;
    logic ok;
    logic [DATA_W-1:0] ctl, e, p, pg;
    int tmo;
    {hresetn, hsel, hwrite, u_cq_valid, u_rc_valid, u_rc_bad_par, u_rc_err} = '0;
    {haddr, hwdata, u_cq_data, u_rc_data} = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    hsel = 1'b1;
    seed = 32'h7408;
    {n_mismatch, tests_run, err_seen, n_pe, x_pe} = '0;
    for (int pass = 0; pass < 2; pass++) begin
      if (pass == 1) hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, REG_CTRL, '0);
      check(rd, 32'h0100_0000);
      ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
      ahb(1'b0, 8'h20, '0);
      check(rd, '0);
      ahb(1'b0, REG_STATUS, '0);
      check({rd[31:5], 2'h0, rd[2:0]}, {31'h0, hresp});
      if (pass == 0) begin
        // every alignment, straddle, variant and width combination
        for (int i = 0; i < 96; i++) begin
          w = (i % 3 == 0) ? WIDTH_256 : ((i % 3 == 1) ? WIDTH_512 : WIDTH_1024);
          b = 5'(i / 3);
          ctl = {5'h0, w, 6'h0, b[4], 1'b0, b[3], b[2], 4'h0, b[1], b[0]};
          ahb(1'b1, REG_CTRL, ctl);
          ahb(1'b0, REG_CTRL, '0);
          check(rd, ctl);
          check({30'h0, lnk.align_r, lnk.align_c}, {30'h0, b[1:0]});
          e = (b[3] && !b[1]) ? ((w == WIDTH_256) ? 2 : (b[4] ? 8 : 4)) : 1;
          check({28'h0, lnk.straddle_rc}, e);
          e = (b[3] && !b[1] && w != WIDTH_256) ? (b[4] ? 4 : 2) : 1;
          check({28'h0, lnk.straddle_rq}, e);
          e = (b[2] && !b[0] && w != WIDTH_256) ? 4 : 1;
          if (e == 1 || b[4]) check({28'h0, lnk.straddle_c}, e);
        end
        // page requests across parity modes, errors and timeouts
        for (int r = 0; r < 5; r++) begin
          p = {12'h0, 16'($random(seed)), 4'(r)};
          pg = $random(seed);
          ok = !ERR_T[r] && !(BAD_T[r] && PM[r] == PAR_GEN_CHECK);
          tmo = (r < 3) ? 3 : 0;
          ahb(1'b1, REG_CTRL, 32'h0100_0004 | {26'h0, PM[r], 4'h0});
          ahb(1'b1, REG_TMO, 32'(tmo));
          ahb(1'b1, REG_PRI, p);
          expect_word(1'b0, p);
          send_rc(pg, BAD_T[r], ERR_T[r]);
          repeat ((tmo + 2) * CPM + 4) @(posedge hclk);
          ahb(1'b0, REG_STATUS, '0);
          e = ok ? ATSP_PRI_DONE : (tmo != 0 ? ATSP_PRI_FAIL : ATSP_PRI_WAIT);
          check({30'h0, rd[1:0]}, e);
          err_seen = err_seen | ERR_T[r];
          check({31'h0, rd[3]}, 32'(err_seen));
          check({31'h0, pri_fail}, {31'h0, e == ATSP_PRI_FAIL});
          if (ok) page[p] = pg;
          // with parity off the cache sends a zero parity bit on rq and cc
          if (PM[r] == PAR_DISABLE) x_pe += int'(^p) + int'(ok && ^pg);
          send_cq(p);
          expect_word(1'b1, page.exists(p) ? page[p] : '0);
        end
        // global invalidate, then a burst deeper than the buffer
        ahb(1'b1, REG_CTRL, 32'h0100_0104);
        ahb(1'b1, REG_CTRL, 32'h0100_0004);
        for (int k = 0; k < 9; k++) send_cq({12'h0, 16'($random(seed)), 4'(k % 5)});
        for (int k = 0; k < 9; k++) expect_word(1'b1, '0);
        ahb(1'b1, REG_TMO, 32'hFFFF_FFFF);
        ahb(1'b0, REG_TMO, '0);
        check(rd, {19'h0, TMO_MAX});
        check(32'(n_pe), 32'(x_pe));
      end
    end
    give_verdict();
  end
endmodule

// File: dv/atsp_link_asserts.sv
// concurrent checks on the stream link joining the two ends
`timescale 1ns/100ps
module atsp_link_asserts
  import atsp_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // completer channels
  input wire logic [DATA_W-1:0] cq_data,
  input wire logic cq_valid,
  input wire logic cq_ready,
  input wire logic cq_par,
  input wire logic [DATA_W-1:0] cc_data,
  input wire logic cc_valid,
  input wire logic cc_par,
  // requester channel
  input wire logic [DATA_W-1:0] rq_data,
  input wire logic rq_valid,
  // agreed configuration
  input wire logic align_c,
  input wire logic align_r,
  input wire logic [3:0] straddle_c,
  input wire logic [3:0] straddle_rc,
  input wire logic [3:0] straddle_rq
);
  // ----------------------------------------
  // single clock domain
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  cq_par_a: assert property (cq_valid |-> cq_par == ^cq_data)
    else $error("cq parity wrong");
  cq_hold_a: assert property (cq_valid && !cq_ready |=> cq_valid && $stable(cq_data))
    else $error("cq beat dropped while stalled");
  cc_par_a: assert property (cc_valid |-> cc_par == ^cc_data || !cc_par)
    else $error("cc parity wrong");
  rq_pulse_a: assert property (rq_valid |=> !rq_valid)
    else $error("rq beat longer than one cycle");
  rq_pasid_a: assert property (rq_valid |-> rq_data[DATA_W-1:PASID_W] == '0)
    else $error("rq data wider than pasid");
  addr_c_a: assert property (align_c && $past(align_c) |-> straddle_c == STRADDLE_NONE)
    else $error("completer straddles while address aligned");
  addr_r_a: assert property (align_r && $past(align_r) |->
    straddle_rc == STRADDLE_NONE && straddle_rq == STRADDLE_NONE)
    else $error("requester straddles while address aligned");
  pair_r_a: assert property (straddle_rc == STRADDLE_EIGHT |-> straddle_rq == STRADDLE_FOUR)
    else $error("requester limits not paired");
  // main scenarios reached
  cover property (rq_valid);
  cover property (cc_valid && cc_data != '0);
  cover property (straddle_rc == STRADDLE_EIGHT);
endmodule
